//--- tb/serial_editor_assertions.sv
/* port checker for the serial mode and line editor.
   assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ps
module serial_editor_checker
   import serial_mode_pkg::*;
(
   // clock, reset, register port
   input wire logic        clock_i,
   input wire logic        resetn_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   // streams and line configuration
   input wire logic        tx_valid_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_port_o,
   input wire logic        tx_ready_i,
   input wire logic        rs485_o,
   input wire logic [1:0]  multidrop_o,
   input wire logic [1:0]  alt_frame_o,
   input wire logic [1:0]  fifo_en_o,
   input wire logic [1:0]  modem_ctl_o,
   input wire logic [1:0]  rts_o,
   input wire logic [1:0]  feedback_en_o,
   input wire logic        test_led_o,
   input wire logic        line_exec_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////////////
   // a mode write, then a quiet cycle so a later write cannot mask it
   sequence s_wr_idle(c);
      wr_i && c ##1 !wr_i;
   endsequence
   property p_lvl(c, lvl);
      s_wr_idle(c) |=> lvl;
   endproperty
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data outside its slot");
   a_unmapped_zero: assert property (rd_i && addr_i > A_STATUS |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_mode_bits: assert property (rd_i && addr_i == A_MODE0 |=> rdata_o[31:13] == 19'h0 && !rdata_o[4])
      else $error("mode readback has a non-flag bit");
   a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_port_o))
      else $error("transmit byte dropped before taken");
   a_exec_pulse: assert property (line_exec_o |=> !line_exec_o)
      else $error("exec pulse too long");
   a_rs485_wins: assert property (rs485_o |-> !multidrop_o[1])
      else $error("multidrop active beside rs485");
   a_rs485_set: assert property (p_lvl(addr_i == A_MODE1 && wdata_i[B_RS485], rs485_o))
      else $error("rs485 flag not applied");
   a_frame_set: assert property (p_lvl(addr_i == A_MODE0 && wdata_i[B_ALTFRAME], alt_frame_o[0]))
      else $error("framing flag not applied");
   a_fifo_clear: assert property (p_lvl(addr_i == A_MODE0 && !wdata_i[B_FIFO], !fifo_en_o[0]))
      else $error("fifo still on");
   a_modem_set: assert property (p_lvl(addr_i == A_MODE0 && wdata_i[B_MODEM], modem_ctl_o[0]))
      else $error("modem lines not asserted");
   a_rts_free: assert property (
      p_lvl(addr_i == A_MODE0 && !wdata_i[B_HWHS], rts_o[0]))
      else $error("rts held low without handshake");
   a_feedback_on: assert property (
      p_lvl(addr_i == A_MODE0 && !wdata_i[B_QUIET], feedback_en_o[0]))
      else $error("feedback off while not quiet");
   a_led_burst: assert property (test_led_o |-> tx_data_o == CH_TEST)
      else $error("activity led outside test burst");
endmodule : serial_editor_checker

bind serial_port_mode_and_line_editor serial_editor_checker chk (.clock_i, .resetn_i, .addr_i,
   .wdata_i, .wr_i, .rd_i, .rdata_o, .tx_valid_o, .tx_data_o, .tx_port_o, .tx_ready_i, .rs485_o,
   .multidrop_o, .alt_frame_o, .fifo_en_o, .modem_ctl_o, .line_exec_o, .rts_o, .feedback_en_o,
   .test_led_o);

//--- tb/serial_host_model.sv
/* terminal on the transmit side: takes bytes, counts them.
   assumes the block holds a byte until ready is seen. */
`timescale 1ns/1ps
module serial_host_model
   import serial_mode_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o,
   output int              byte_count_o,
   output int              w_count_o
);
   // a slow terminal stalls at random, so hold logic is exercised
   always @(posedge clock_i)
   begin
      if (tx_valid_i && tx_ready_o)
      begin
         byte_count_o <= byte_count_o + 1;
         w_count_o <= w_count_o + int'(tx_data_i == CH_TEST);
      end
      tx_ready_o <= ($urandom % 4) != 0;
   end
endmodule : serial_host_model

//--- tb/serial_port_mode_and_line_editor_bench.sv
/* self-checking bench for the serial mode and line editor.
   assumes the host model on the transmit side and the bound checker. */
`timescale 1ns/1ps
module serial_port_mode_and_line_editor_bench
   import serial_mode_pkg::*;
;
   logic         clock_i, resetn_i, wr_i, rd_i, rx_valid_i, tx_ready_i, rd_seen;
   logic         rx_ready_o, tx_valid_o, line_exec_o;
   logic [7:0]   addr_i, rx_data_i, tx_data_o, r1, r2, r3;
   logic [31:0]  wdata_i, rdata_o, v;
   logic [4:0]   line_len_o;
   logic [127:0] line_data_o, mask;
   logic [135:0] exp, got;
   logic [135:0] exp_q[$];
   int           failures, check_count, bytes, wcnt, base, n;

   serial_port_mode_and_line_editor #(.ID_DEFAULT(16'h002a)) dut ( // id arbitrary
      .clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_valid_i,
      .rx_data_i, .rx_port_i(1'b0), .rx_perr_i(1'b0), .rx_ready_o, .tx_valid_o, .tx_data_o,
      .tx_port_o(), .tx_ready_i, .cts_i(2'b11), .logged_on_i(2'b00), .rts_o(), .modem_ctl_o(),
      .rs485_o(), .multidrop_o(), .alt_frame_o(), .fifo_en_o(), .feedback_en_o(),
      .test_led_o(), .line_exec_o, .line_port_o(), .line_len_o, .line_data_o);
   serial_host_model host (.clock_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_ready_o(tx_ready_i), .byte_count_o(bytes), .w_count_o(wcnt));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic bad(input string m);
      failures++;
      $display("BAD %0t %s", $time, m);
   endtask : bad
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back({104'h0, e});
      @(posedge clock_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
   endtask : rd
   // valid holds until ready is sampled high
   task automatic rx(input logic [7:0] c);
      @(posedge clock_i);
      rx_valid_i <= 1'b1;
      rx_data_i <= c;
      n = 0;
      do @(posedge clock_i); while (!rx_ready_o && ++n < 300);
      rx_valid_i <= 1'b0;
      if (n >= 300)
      begin
         bad("receive stalled");
         report_and_stop();
      end
   endtask : rx
   // bounded wait on a host count, then settle and compare exactly
   task automatic wait_cnt(input bit use_w, input int target);
      n = 0;
      while ((use_w ? wcnt : bytes - base) < target && n++ < 20000)
         @(posedge clock_i);
      repeat (40) @(posedge clock_i);
      check_count++;
      if ((use_w ? wcnt : bytes - base) != target)
      begin
         bad("transmit count wrong");
         report_and_stop();
      end
   endtask : wait_cnt
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock_i)
   begin
      if (rd_seen || line_exec_o)
      begin
         check_count++;
         exp = exp_q.size() ? exp_q.pop_front() : 'x;
         mask = rd_seen ? 128'hffffffff : ~(128'h0) >> (128 - 8 * exp[132:128]);
         got = rd_seen ? {104'h0, rdata_o} : {3'h0, line_len_o, line_data_o};
         if ((got & {8'hff, mask}) !== exp)
            bad("result differs from expected");
      end
      rd_seen = rd_i;
   end
   initial
   begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   initial
   begin
      {resetn_i, wr_i, rd_i, rx_valid_i, addr_i, rx_data_i, wdata_i} = '0;
      void'($urandom(83676));
      repeat (12) @(posedge clock_i);
      resetn_i <= 1'b1;
      rd(A_MODE0, 32'h0380);
      rd(A_ID, 32'h002a);
      wr(A_MODE0, 32'h09c0);
      v = ($urandom & 32'h1fff) | 32'h0420;
      wr(A_MODE1, v);
      rd(A_MODE1, v & 32'h1fef);
      rd(A_MODE0, 32'h09c0);
      rd(8'h20, 32'h0);
      wr(A_CTRL, 32'h1);
      wait_cnt(1'b1, 256);
      r1 = 8'h61 + 8'($urandom % 22);
      r2 = 8'h61 + 8'($urandom % 22);
      r3 = 8'h61 + 8'($urandom % 22);
      rx(CH_CTRL_T);
      exp_q.push_back({3'h0, 5'd2, 112'h0, r3, r1});
      rx(r1);
      rx(r2);
      rx(CH_BS);
      rx(r3);
      rx(CH_CR);
      exp_q.push_back({3'h0, 5'd1, 120'h0, r2});
      rx(r1);
      rx(CH_ESC);
      rx(r2);
      rx(CH_CR);
      rx(CH_CTRL_C);
      repeat (40) @(posedge clock_i);
      base = bytes;
      rx(CH_QMARK);
      rx(CH_CR);
      wait_cnt(1'b0, HELP_LEN);
      if (exp_q.size() != 0)
         bad("expected result never seen");
      report_and_stop();
   end
endmodule : serial_port_mode_and_line_editor_bench

//--- verilog/serial_mode_pkg.sv
/*
 * constants, register offsets, mode flag positions and character codes for the
 * serial port mode and line editor block.
 * assumes a byte-wide character stream from a uart and a plain register port.
 */
// Functional notes
// - rs485 flag 1024 switches second port to rs485; beats multi-drop.
// - multi-drop flag 32: act only on lines carrying our identifier.
// - modem flag 64: send init string, assert modem control lines.
// - handshake flag 8: pace transmit with cts, drive rts.
// - flag 256 enables xon/xoff pausing of our transmitter.
// - flag 512 enables fifo; off means one character at a time.
// - flag 128 tolerates parity errors by keeping the character.
// - prompt flag 4096 emits a prompt in terminal mode.
// - framing flag 2048 selects even parity, seven bits, one stop.
// - error checking, xon/xoff and fifo flags reset to on.
// - each port keeps its own independent mode flags.
// - port test sends 256 'w' characters, blinking the activity led.
// - identifier register with fixed reset default.
// - control-t enters terminal mode with echo and editing.
// - interactive use only while quiet and computer flags are clear.
// - control-c outside a listing leaves terminal mode.
// - lines execute only when carriage return arrives.
// - backspace removes the last pending character in interactive use.
// - escape discards the whole pending line in interactive use.
// - question mark line with optional id sends the command list.
// - during listing control-c pauses, control-p resumes.
// - quiet flag 1 suppresses unsolicited feedback.
// - computer flag 2 disables echo.
// - security flag 4 blocks all but help until logged on.
// - mode readback equals sum of enabled flag values.
package serial_mode_pkg;
   localparam int              MODE_W     = 13;
   localparam int              ID_W       = 16;
   localparam int              B_QUIET    = 0;
   localparam int              B_COMPUTER = 1;
   localparam int              B_SECURE   = 2;
   localparam int              B_HWHS     = 3;
   localparam int              B_MULTI    = 5;
   localparam int              B_MODEM    = 6;
   localparam int              B_ERRCHK   = 7;
   localparam int              B_XONXOFF  = 8;
   localparam int              B_FIFO     = 9;
   localparam int              B_RS485    = 10;
   localparam int              B_ALTFRAME = 11;
   localparam int              B_PROMPT   = 12;
   localparam logic [12:0]     MODE_RESET = 13'h0380;
   localparam logic [12:0]     MODE_MASK  = 13'h1fef;
   localparam logic [7:0]      A_MODE0    = 8'h00;
   localparam logic [7:0]      A_MODE1    = 8'h04;
   localparam logic [7:0]      A_ID       = 8'h08;
   localparam logic [7:0]      A_CTRL     = 8'h0c;
   localparam logic [7:0]      A_STATUS   = 8'h10;
   localparam logic [7:0]      CH_CTRL_C  = 8'h03;
   localparam logic [7:0]      CH_BS      = 8'h08;
   localparam logic [7:0]      CH_CR      = 8'h0d;
   localparam logic [7:0]      CH_CTRL_P  = 8'h10;
   localparam logic [7:0]      CH_XON     = 8'h11;
   localparam logic [7:0]      CH_XOFF    = 8'h13;
   localparam logic [7:0]      CH_CTRL_T  = 8'h14;
   localparam logic [7:0]      CH_ESC     = 8'h1b;
   localparam logic [7:0]      CH_ZERO    = 8'h30;
   localparam logic [7:0]      CH_NINE    = 8'h39;
   localparam logic [7:0]      CH_PROMPT  = 8'h3e;
   localparam logic [7:0]      CH_QMARK   = 8'h3f;
   localparam logic [7:0]      CH_TEST    = 8'h77;
   localparam logic [8:0]      TEST_LAST  = 9'h0ff;
   localparam int              HELP_LEN   = 47;
   localparam logic [8*HELP_LEN-1:0] HELP_TEXT =
      "C CAL\015\nD DIAG\015\nL LOGON\015\nT TEST\015\nV VAR\015\nW WARN\015\n";
   localparam int              MODEM_LEN  = 4;
   localparam logic [8*MODEM_LEN-1:0] MODEM_TEXT = "ATZ\015";
   typedef enum logic [2:0] {
      SRC_IDLE   = 3'b000,
      SRC_ECHO   = 3'b001,
      SRC_PROMPT = 3'b010,
      SRC_HELP   = 3'b011,
      SRC_MODEM  = 3'b100,
      SRC_TEST   = 3'b101
   } src_t;
endpackage : serial_mode_pkg

//--- verilog/serial_port_mode_and_line_editor.sv
/*
 * mode flags for two serial ports, port test burst, terminal line editor,
 * help listing and transmit sequencer.
 * assumes a uart outside that delivers received bytes with port tag and
 * parity error, and accepts transmit bytes with valid/ready.
 */
`timescale 1ns/1ps
module serial_port_mode_and_line_editor
   import serial_mode_pkg::*;
#(
   parameter int              LINE_MAX   = 16,
   parameter logic [ID_W-1:0] ID_DEFAULT = 16'h0001  // arbitrary value
)
(
   // clock and reset
   input  wire logic                  clock_i,
   input  wire logic                  resetn_i,
   // register port
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [31:0]           rdata_o,
   // receive stream
   input  wire logic                  rx_valid_i,
   input  wire logic [7:0]            rx_data_i,
   input  wire logic                  rx_port_i,
   input  wire logic                  rx_perr_i,
   output logic                       rx_ready_o,
   // transmit stream
   output logic                       tx_valid_o,
   output logic      [7:0]            tx_data_o,
   output logic                       tx_port_o,
   input  wire logic                  tx_ready_i,
   // line handshake and logon state
   input  wire logic [1:0]            cts_i,
   input  wire logic [1:0]            logged_on_i,
   output logic      [1:0]            rts_o,
   // uart and line configuration
   output logic      [1:0]            modem_ctl_o,
   output logic                       rs485_o,
   output logic      [1:0]            multidrop_o,
   output logic      [1:0]            alt_frame_o,
   output logic      [1:0]            fifo_en_o,
   output logic      [1:0]            feedback_en_o,
   output logic                       test_led_o,
   // executed command line
   output logic                       line_exec_o,
   output logic                       line_port_o,
   output logic      [$clog2(LINE_MAX+1)-1:0] line_len_o,
   output logic      [8*LINE_MAX-1:0] line_data_o
);

   localparam int LEN_W = $clog2(LINE_MAX+1);

   typedef struct packed {
      logic [1:0][MODE_W-1:0]   mode;
      logic [ID_W-1:0]          id;
      logic [1:0]               term;
      logic [1:0]               xoff;
      logic                     started;
      logic [31:0]              rdata;
      logic [LINE_MAX-1:0][7:0] line;
      logic [LEN_W-1:0]         len;
      logic                     lport;
      logic                     exec;
      logic                     eport;
      logic [LEN_W-1:0]         elen;
      logic                     echo_pend;
      logic [7:0]               echo_char;
      logic                     echo_port;
      logic                     prompt_pend;
      logic                     prompt_port;
      logic                     help_pend;
      logic                     help_port;
      logic                     paused;
      logic [1:0]               modem_pend;
      logic                     test_pend;
      logic                     test_port;
      logic                     busy;
      src_t                     src;
      logic                     tport;
      logic [8:0]               idx;
      logic                     txv;
      logic [7:0]               txd;
      logic                     gap;
      logic                     rxr;
      logic [1:0]               rts;
      logic [1:0]               modem_ctl;
      logic                     rs485;
      logic [1:0]               mdrop;
      logic [1:0]               alt;
      logic [1:0]               fifo;
      logic [1:0]               fb;
      logic                     led;
   } state_t;

   state_t s;
   state_t n;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [8:0] job_last(input src_t src);
      case (src)
         SRC_HELP:  job_last = 9'(HELP_LEN - 1);
         SRC_MODEM: job_last = 9'(MODEM_LEN - 1);
         SRC_TEST:  job_last = TEST_LAST;
         default:   job_last = 9'h000;
      endcase
   endfunction : job_last

   function automatic logic [7:0] job_char(input src_t src, input logic [8:0] idx,
                                           input logic [7:0] echo);
      case (src)
         SRC_ECHO:   job_char = echo;
         SRC_PROMPT: job_char = CH_PROMPT;
         SRC_HELP:   job_char = HELP_TEXT[8*(HELP_LEN-1-int'(idx)) +: 8];
         SRC_MODEM:  job_char = MODEM_TEXT[8*(MODEM_LEN-1-int'(idx[1:0])) +: 8];
         SRC_TEST:   job_char = CH_TEST;
         default:    job_char = 8'h00;
      endcase
   endfunction : job_char

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic             p;
      logic [7:0]       c;
      logic             interactive;
      logic             listing;
      logic             allowed;
      logic             got;
      logic             stop;
      logic             help;
      logic             id_ok;
      logic             md_eff;
      logic [ID_W-1:0]  pid;
      p           = rx_port_i;
      c           = rx_data_i;
      interactive = 1'b0;
      listing     = 1'b0;
      allowed     = 1'b0;
      got         = 1'b0;
      stop        = 1'b0;
      help        = 1'b0;
      id_ok       = 1'b0;
      md_eff      = 1'b0;
      pid         = '0;
      n           = s;
      n.exec      = 1'b0;
      n.rdata     = 32'h0000_0000;

      // power-up modem init, sent once per port that has the flag
      if (!s.started)
      begin
         n.started = 1'b1;
         for (int q = 0; q < 2; q++)
            n.modem_pend[q] = s.mode[q][B_MODEM];
      end

      // transmit sequencer; runs before receive so a new request wins
      allowed = (!s.mode[s.tport][B_HWHS] || cts_i[s.tport])
                && (!s.mode[s.tport][B_XONXOFF] || !s.xoff[s.tport])
                && !(s.src == SRC_HELP && s.paused);
      if (s.txv)
      begin
         if (tx_ready_i)
         begin
            n.txv = 1'b0;
            // without fifo leave a gap so the uart sees one byte at a time
            n.gap = !s.mode[s.tport][B_FIFO];
            if (s.idx == job_last(s.src))
            begin
               n.busy = 1'b0;
               n.src  = SRC_IDLE;
               if (s.src == SRC_HELP)
                  n.paused = 1'b0;
            end
            else
               n.idx = s.idx + 9'h001;
         end
      end
      else if (s.gap)
         n.gap = 1'b0;
      else if (s.busy)
      begin
         if (allowed)
         begin
            n.txv = 1'b1;
            n.txd = job_char(s.src, s.idx, s.echo_char);
         end
      end
      else
      begin
         n.idx = 9'h000;
         if (s.echo_pend)
         begin
            n.busy = 1'b1; n.src = SRC_ECHO; n.tport = s.echo_port; n.echo_pend = 1'b0;
         end
         else if (s.prompt_pend)
         begin
            n.busy = 1'b1; n.src = SRC_PROMPT; n.tport = s.prompt_port;
            n.prompt_pend = 1'b0;
         end
         else if (s.help_pend)
         begin
            n.busy = 1'b1; n.src = SRC_HELP; n.tport = s.help_port; n.help_pend = 1'b0;
         end
         else if (s.modem_pend != 2'b00)
         begin
            n.busy  = 1'b1;
            n.src   = SRC_MODEM;
            n.tport = !s.modem_pend[0];
            n.modem_pend[!s.modem_pend[0]] = 1'b0;
         end
         else if (s.test_pend)
         begin
            n.busy = 1'b1; n.src = SRC_TEST; n.tport = s.test_port; n.test_pend = 1'b0;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // receive and line editing
      interactive = s.term[p] && !s.mode[p][B_QUIET] && !s.mode[p][B_COMPUTER];
      listing = s.help_pend && s.help_port == p
                || s.busy && s.src == SRC_HELP && s.tport == p;
      md_eff  = s.mode[p][B_MULTI] && !(p && s.mode[1][B_RS485]);
      if (rx_valid_i && s.rxr && !(rx_perr_i && !s.mode[p][B_ERRCHK]))
      begin
         if (rx_perr_i)
            c = {1'b0, rx_data_i[6:0]};
         if (s.mode[p][B_XONXOFF] && (c == CH_XOFF || c == CH_XON))
            n.xoff[p] = (c == CH_XOFF);
         else if (c == CH_CTRL_T)
         begin
            n.term[p] = 1'b1;
            if (s.mode[p][B_PROMPT] && !s.mode[p][B_QUIET] && !s.mode[p][B_COMPUTER])
            begin
               n.prompt_pend = 1'b1;
               n.prompt_port = p;
            end
         end
         else if (c == CH_CTRL_C)
         begin
            if (listing)
               n.paused = 1'b1;
            else
               n.term[p] = 1'b0;
         end
         else if (c == CH_CTRL_P)
         begin
            if (listing)
               n.paused = 1'b0;
         end
         // a line already begun on the other port keeps the buffer
         else if (s.len != '0 && s.lport != p)
            n.len = s.len;
         else if (c == CH_CR)
         begin
            help = s.len != '0 && s.line[0] == CH_QMARK;
            for (int i = 1; i < LINE_MAX; i++)
               if (i < int'(s.len) && !stop)
               begin
                  if (s.line[i] >= CH_ZERO && s.line[i] <= CH_NINE)
                  begin
                     pid = ID_W'(pid * 16'd10 + {8'h00, s.line[i] - CH_ZERO});
                     got = 1'b1;
                  end
                  else if (got)
                     stop = 1'b1;
               end
            id_ok = got ? (pid == s.id) : !md_eff;
            if (help && id_ok)
            begin
               if (!listing)
               begin
                  n.help_pend = 1'b1;
                  n.help_port = p;
                  n.paused    = 1'b0;
               end
            end
            else if (s.len != '0 && id_ok && !help
                     && (!s.mode[p][B_SECURE] || logged_on_i[p]))
            begin
               n.exec  = 1'b1;
               n.eport = p;
               n.elen  = s.len;
            end
            n.len = '0;
            if (interactive && s.mode[p][B_PROMPT])
            begin
               n.prompt_pend = 1'b1;
               n.prompt_port = p;
            end
            if (interactive)
            begin
               n.echo_pend = 1'b1; n.echo_char = c; n.echo_port = p;
            end
         end
         else if (c == CH_BS && interactive)
         begin
            if (s.len != '0)
               n.len = s.len - LEN_W'(1);
            n.echo_pend = 1'b1; n.echo_char = c; n.echo_port = p;
         end
         else if (c == CH_ESC && interactive)
            n.len = '0;
         else if (int'(s.len) < LINE_MAX)
         begin
            n.line[s.len] = c;
            n.len   = s.len + LEN_W'(1);
            n.lport = p;
            if (interactive)
            begin
               n.echo_pend = 1'b1;
               n.echo_char = c;
               n.echo_port = p;
            end
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // register port
      if (wr_i)
         case (addr_i)
            A_MODE0, A_MODE1:
            begin
               n.mode[addr_i[2]] = wdata_i[MODE_W-1:0] & MODE_MASK;
               if (wdata_i[B_MODEM] && !s.mode[addr_i[2]][B_MODEM])
                  n.modem_pend[addr_i[2]] = 1'b1;
            end
            A_ID:
               n.id = wdata_i[ID_W-1:0];
            A_CTRL:
               if (wdata_i[0] && !s.test_pend && !(s.busy && s.src == SRC_TEST))
               begin
                  n.test_pend = 1'b1;
                  n.test_port = wdata_i[1];
               end
            default:
               n.id = n.id;
         endcase
      if (rd_i)
         case (addr_i)
            A_MODE0:  n.rdata = {19'h00000, s.mode[0]};
            A_MODE1:  n.rdata = {19'h00000, s.mode[1]};
            A_ID:     n.rdata = {16'h0000, s.id};
            A_CTRL:   n.rdata = {30'h00000000, s.test_port,
                                 s.test_pend || (s.busy && s.src == SRC_TEST)};
            A_STATUS: n.rdata = {16'h0000, s.xoff, 1'b0, 5'(s.len), 2'b00, s.busy,
                                 s.test_pend || (s.busy && s.src == SRC_TEST), s.paused,
                                 s.help_pend || (s.busy && s.src == SRC_HELP), s.term};
            default:  n.rdata = 32'h0000_0000;
         endcase

      ////////////////////////////////////////////////////////////////////////
      // registered configuration outputs
      n.rxr = !n.echo_pend;
      for (int q = 0; q < 2; q++)
      begin
         n.rts[q]       = !n.mode[q][B_HWHS] || n.rxr;
         n.modem_ctl[q] = n.mode[q][B_MODEM];
         n.alt[q]       = n.mode[q][B_ALTFRAME];
         n.fifo[q]      = n.mode[q][B_FIFO];
         n.fb[q]        = !n.mode[q][B_QUIET];
      end
      n.mdrop[0] = n.mode[0][B_MULTI];
      n.mdrop[1] = n.mode[1][B_MULTI] && !n.mode[1][B_RS485];
      n.rs485    = n.mode[1][B_RS485];
      n.led      = n.busy && n.src == SRC_TEST && n.idx[3];
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s      <= '0;
         s.mode <= {MODE_RESET, MODE_RESET};
         s.id   <= ID_DEFAULT;
         s.rxr  <= 1'b1;
         s.rts  <= 2'b11;
         s.fifo <= 2'b11;
         s.fb   <= 2'b11;
      end
      else
         s <= n;
   end

   assign rdata_o       = s.rdata;
   assign rx_ready_o    = s.rxr;
   assign tx_valid_o    = s.txv;
   assign tx_data_o     = s.txd;
   assign tx_port_o     = s.tport;
   assign rts_o         = s.rts;
   assign modem_ctl_o   = s.modem_ctl;
   assign rs485_o       = s.rs485;
   assign multidrop_o   = s.mdrop;
   assign alt_frame_o   = s.alt;
   assign fifo_en_o     = s.fifo;
   assign feedback_en_o = s.fb;
   assign test_led_o    = s.led;
   assign line_exec_o   = s.exec;
   assign line_port_o   = s.eport;
   assign line_len_o    = s.elen;
   assign line_data_o   = s.line;

endmodule : serial_port_mode_and_line_editor
